// ===== bench/ccu_timer_model.sv
module ccu_timer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timer resets from the unit
  input wire logic first_timer_reset,
  input wire logic third_timer_reset,
  // Timer counts
  output logic [15:0] first_timer_count,
  output logic [15:0] third_timer_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Third timer starts offset so a match shows which timer was selected
  always_ff @(posedge clk) begin
    if (rst) begin
      first_timer_count <= 16'h0000;
      third_timer_count <= 16'h8000;
    end else begin
      first_timer_count <= first_timer_reset ? 16'h0000 : first_timer_count + 16'h0001;
      third_timer_count <= third_timer_reset ? 16'h0000 : third_timer_count + 16'h0001;
    end
  end
endmodule // ccu_timer_model

// ===== bench/tb.sv
`include "ccu_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [1:0] cap = 2'b00;
  logic [7:0] st_cnt = 8'h00;
  logic [1:0] st_fine = 2'b00;
  logic st_wrap = 1'b0;
  logic [1:0] pin, oe, sev;
  logic [15:0] t1, t3;
  logic t1r, t3r, irq;
  int miscompares = 0;
  int checked = 0;
  int n_sev = 0;
  int n_t1r = 0;
  int n_t3r = 0;

  always #4 clk = ~clk;

  ccu_compare_unit ccu_compare_unit_inst (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .first_timer_count(t1),
    .third_timer_count(t3), .first_timer_reset(t1r), .third_timer_reset(t3r),
    .second_timer_count(st_cnt), .second_timer_fine(st_fine), .second_timer_wrap(st_wrap),
    .cap_event(cap), .unit_output_pin(pin), .unit_output_pin_oe(oe), .special_event(sev),
    .irq(irq));

  ccu_timer_model ccu_timer_model_inst (.clk(clk), .rst(rst), .first_timer_reset(t1r),
    .third_timer_reset(t3r), .first_timer_count(t1), .third_timer_count(t3));

  // Pulse counters for trigger and timer resets
  always @(posedge clk) begin
    n_sev <= n_sev + int'(sev[0]);
    n_t1r <= n_t1r + int'(t1r);
    n_t3r <= n_t3r + int'(t3r);
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic t_regs;
    logic [7:0] d;
    chk("oe at reset", 16'(oe), 16'h0000);
    wr(`CCU_CTRL, 8'hFF);
    rd(`CCU_CTRL, d);
    chk("ctrl top bits", 16'(d), 16'h003F);
    wr(`CCU_CTRL, 8'h00);
    rd(4'hF, d);
    chk("unmapped", 16'(d), 16'h0000);
    wr(`CCU_CMP_LO + `CCU_UNIT_STRIDE, 8'hA5);
    rd(`CCU_CMP_LO + `CCU_UNIT_STRIDE, d);
    chk("enhanced low", 16'(d), 16'h00A5);
    wr(`CCU_TSEL, 8'hFF);
    rd(`CCU_TSEL, d);
    chk("timer select", 16'(d), 16'h0048);
    wr(`CCU_TSEL, 8'h00);
    wr(`CCU_PORT, 8'h08);
    @(posedge clk);
    chk("oe driven", 16'(oe[0]), 16'h0001);
    $display("test regs done");
  endtask

  task automatic t_pwm;
    logic [7:0] d;
    wr(`CCU_CMP_LO, 8'h03);
    wr(`CCU_CTRL, 8'h2C);
    wr(`CCU_CMP_HI, 8'h55);
    rd(`CCU_CMP_HI, d);
    chk("pwm high locked", 16'(d), 16'h0000);
    st_wrap <= 1'b1;
    @(posedge clk);
    st_wrap <= 1'b0;
    @(posedge clk);
    chk("pwm period start", 16'(pin[0]), 16'h0001);
    rd(`CCU_CMP_HI, d);
    chk("pwm duty latched", 16'(d), 16'h0003);
    chk("pwm still high", 16'(pin[0]), 16'h0001);
    st_cnt <= 8'h03;
    st_fine <= 2'b10;
    @(posedge clk);
    @(posedge clk);
    chk("pwm duty end", 16'(pin[0]), 16'h0000);
    st_cnt <= 8'h00;
    st_fine <= 2'b00;
    wr(`CCU_CTRL, 8'h00);
    $display("test pwm done");
  endtask

  task automatic t_capture;
    logic [7:0] d;
    wr(`CCU_CTRL, 8'h06);
    repeat (2) begin
      @(posedge clk);
      cap <= 2'b01;
      @(posedge clk);
      cap <= 2'b00;
    end
    rd(`CCU_PRESC, d);
    chk("prescaler counted", 16'(d[3:0]), 16'h0002);
    wr(`CCU_CTRL, 8'h00);
    rd(`CCU_PRESC, d);
    chk("prescaler", 16'(d[3:0]), 16'h0000);
    $display("test capture done");
  endtask

  task automatic t_compare(input logic sel);
    logic [3:0] md [6] = '{`CCU_MODE_SET, `CCU_MODE_CLR, `CCU_MODE_TOGGLE,
      `CCU_MODE_TOGGLE, `CCU_MODE_SWI, `CCU_MODE_TRIG};
    logic [7:0] pt [6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h09, 8'h08};
    logic [5:0] en = 6'b110111;
    logic [5:0] clr = 6'b001001;
    logic [5:0] ep = 6'b011101;
    logic [7:0] d;
    logic [15:0] c;
    logic trg;
    int s0, a1, a3;
    wr(`CCU_TSEL, {1'b0, sel, 6'h00});
    for (int i = 0; i < 6; i++) begin
      trg = (md[i] == `CCU_MODE_TRIG);
      wr(`CCU_FLAGS, 8'h03);
      wr(`CCU_ENABLES, {7'h00, en[i]});
      wr(`CCU_PORT, pt[i]);
      if (clr[i]) wr(`CCU_CTRL, 8'h00);
      wr(`CCU_CTRL, {4'h0, md[i]});
      s0 = n_sev;
      a1 = n_t1r;
      a3 = n_t3r;
      c = (sel ? t3 : t1) + 16'h0028;
      wr(`CCU_CMP_HI, c[15:8]);
      wr(`CCU_CMP_LO, c[7:0]);
      d = 8'h00;
      for (int k = 0; k < 60 && d[0] !== 1'b1; k++) rd(`CCU_FLAGS, d);
      chk("flag", 16'(d[0]), 16'h0001);
      chk("pin", 16'(pin[0]), 16'(ep[i]));
      chk("irq", 16'(irq), 16'(en[i]));
      chk("trigger", 16'(n_sev - s0), 16'(trg));
      chk("first reset", 16'(n_t1r - a1), 16'(trg & !sel));
      chk("third reset", 16'(n_t3r - a3), 16'(trg & sel));
      wr(`CCU_FLAGS, 8'h01);
      rd(`CCU_FLAGS, d);
      chk("flag cleared", 16'(d[0]), 16'h0000);
      chk("irq cleared", 16'(irq), 16'h0000);
    end
    $display("test compare done");
  endtask

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pwm;
    t_capture;
    t_compare(1'b0);
    t_compare(1'b1);
    end_of_test;
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    end_of_test;
  end
endmodule // tb

// ===== design/ccu_compare_unit.sv
// Our own choices: the plain strobed port and the address map.
`include "ccu_params.svh"

module ccu_compare_unit #(
  parameter int HAS_ENH = 1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Timer counts
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] third_timer_count,
  output logic first_timer_reset,
  output logic third_timer_reset,
  // PWM time base
  input wire logic [7:0] second_timer_count,
  input wire logic [1:0] second_timer_fine,
  input wire logic second_timer_wrap,
  // Capture edge events
  input wire logic [1:0] cap_event,
  // Pins and triggers
  output logic [1:0] unit_output_pin,
  output logic [1:0] unit_output_pin_oe,
  output logic [1:0] special_event,
  output logic irq
);
  import ccu_pkg::*;

  localparam int NU = (HAS_ENH != 0) ? 2 : 1;

  if (HAS_ENH != 0 && HAS_ENH != 1) begin : g_bad_enh
    $error("HAS_ENH must be 0 or 1");
  end

  ccu_state_t s;
  ccu_state_t next_s;

  logic [1:0][3:0] mode;
  logic [1:0] use_t3;
  logic [1:0][15:0] tbase;
  logic [1:0] hit;
  logic [1:0] drive;
  logic [1:0] w1c;

  // Time base choice for each unit
  function automatic logic sel_t3(
    input logic [1:0] t,
    input int u
  );
    if (u == 0) begin
      return t[1];
    end
    return t[1] | t[0];
  endfunction

  // Pin action from the mode field
  function automatic ccu_act_t act_of(input logic [3:0] m);
    unique case (m)
      `CCU_MODE_SET: return CCU_ACT_HIGH;
      `CCU_MODE_CLR: return CCU_ACT_LOW;
      `CCU_MODE_TOGGLE: return CCU_ACT_TOGGLE;
      default: return CCU_ACT_NONE;
    endcase
  endfunction

  function automatic logic is_cmp(input logic [3:0] m);
    return (m == `CCU_MODE_TOGGLE) || (m[3:2] == 2'b10);
  endfunction

  function automatic logic [3:0] ubase(
    input int u,
    input logic [3:0] off
  );
    return 4'(off + u * `CCU_UNIT_STRIDE);
  endfunction

  always_comb begin
    next_s = s;
    next_s.spev = '0;
    next_s.t1rst = 1'b0;
    next_s.t3rst = 1'b0;
    next_s.rdata = '0;
    mode = '0;
    use_t3 = '0;
    tbase = '0;
    hit = '0;
    drive = '0;
    w1c = '0;

    for (int u = 0; u < NU; u++) begin
      mode[u] = s.ctrl[u][3:0];
      use_t3[u] = sel_t3(s.tsel, u); // R17
      tbase[u] = use_t3[u] ? third_timer_count : first_timer_count;
      // Level compare, one event per entry into equality
      next_s.eq[u] = is_cmp(mode[u])
        && ({s.cmp_hi[u], s.cmp_lo[u]} == tbase[u]); // R1
      hit[u] = next_s.eq[u] && !s.eq[u];

      unique case (act_of(mode[u]))
        CCU_ACT_HIGH: begin
          if (hit[u]) begin
            next_s.clat[u] = 1'b1; // R2 R18
          end
        end
        CCU_ACT_LOW: begin
          if (hit[u]) begin
            next_s.clat[u] = 1'b0; // R2 R18
          end
        end
        CCU_ACT_TOGGLE: begin
          if (hit[u]) begin
            next_s.clat[u] = ~s.clat[u]; // R2 R18
          end
        end
        CCU_ACT_NONE: begin
        end
      endcase

      if (hit[u] && mode[u] == `CCU_MODE_TRIG) begin
        next_s.spev[u] = 1'b1; // R6
        if (use_t3[u]) begin
          next_s.t3rst = 1'b1; // R7
        end else begin
          next_s.t1rst = 1'b1; // R7
        end
      end

      // Waveform with ten-bit duty, double buffered
      if (mode[u][3:2] == `CCU_MODE_PWM) begin
        if (second_timer_wrap) begin
          next_s.cmp_hi[u] = s.cmp_lo[u];
          next_s.dlat2[u] = s.ctrl[u][5:4];
          next_s.clat[u] = ({s.cmp_lo[u], s.ctrl[u][5:4]} != 10'h000); // R11
        end else if ({s.cmp_hi[u], s.dlat2[u]}
            == {second_timer_count, second_timer_fine}) begin
          next_s.clat[u] = 1'b0; // R11
        end
      end

      // Prescaler counts only while capturing
      if (mode[u][3:2] != `CCU_MODE_CAP) begin
        next_s.presc[u] = '0; // R15
      end else if (cap_event[u]) begin
        next_s.presc[u] = s.presc[u] + 4'h1;
      end
    end

    // Register writes
    if (wr_en) begin
      for (int u = 0; u < NU; u++) begin
        if (addr == ubase(u, `CCU_CMP_LO)) begin
          next_s.cmp_lo[u] = wdata;
        end
        if (addr == ubase(u, `CCU_CMP_HI)
            && mode[u][3:2] != `CCU_MODE_PWM) begin
          next_s.cmp_hi[u] = wdata;
        end
        if (addr == ubase(u, `CCU_CTRL)) begin
          next_s.ctrl[u] = wdata[5:0]; // R13
        end
      end
      if (addr == `CCU_TSEL) begin
        next_s.tsel = {wdata[`CCU_TSEL_HIGH], wdata[`CCU_TSEL_LOW]};
      end
      if (addr == `CCU_FLAGS) begin
        w1c = wdata[1:0];
      end
      if (addr == `CCU_ENABLES) begin
        next_s.en = wdata[1:0];
      end
      if (addr == `CCU_PORT) begin
        next_s.port = wdata[3:0];
      end
    end

    for (int u = 0; u < NU; u++) begin
      // Unit off holds the compare latch low
      if (next_s.ctrl[u][3:0] == `CCU_MODE_OFF) begin
        next_s.clat[u] = 1'b0; // R8
      end
      drive[u] = (act_of(next_s.ctrl[u][3:0]) != CCU_ACT_NONE)
        || (next_s.ctrl[u][3:2] == `CCU_MODE_PWM);
      // Without a pin action or PWM mode the pin shows the port latch
      next_s.pout[u] = drive[u] ? next_s.clat[u]
        : next_s.port[2 * u + `CCU_PORT_LATCH]; // R3 R5
      next_s.poe[u] = !next_s.port[2 * u + `CCU_PORT_DIR];
    end

    // Set wins over a same-cycle clear
    next_s.flags = (s.flags & ~w1c) | hit; // R4 R16
    next_s.irq = |(next_s.flags & next_s.en); // R5

    // Read data, one cycle after the strobe
    if (rd_en) begin
      for (int u = 0; u < NU; u++) begin
        if (addr == ubase(u, `CCU_CMP_LO)) begin
          next_s.rdata = s.cmp_lo[u];
        end
        if (addr == ubase(u, `CCU_CMP_HI)) begin
          next_s.rdata = s.cmp_hi[u];
        end
        if (addr == ubase(u, `CCU_CTRL)) begin
          next_s.rdata = {2'b00, s.ctrl[u]}; // R13
        end
      end
      unique case (addr)
        `CCU_TSEL: begin
          next_s.rdata[`CCU_TSEL_HIGH] = s.tsel[1];
          next_s.rdata[`CCU_TSEL_LOW] = s.tsel[0];
        end
        `CCU_FLAGS: next_s.rdata = {6'h00, s.flags};
        `CCU_ENABLES: next_s.rdata = {6'h00, s.en};
        `CCU_PORT: next_s.rdata = {4'h0, s.port};
        `CCU_PRESC: next_s.rdata = {s.presc[1], s.presc[0]};
        default: begin
        end
      endcase
    end

    // Absent enhanced unit stays silent
    if (NU == 1) begin
      next_s.flags[1] = 1'b0; // R14
      next_s.en[1] = 1'b0;
      next_s.port[3:2] = 2'b10;
      next_s.poe[1] = 1'b0;
      next_s.pout[1] = 1'b0;
      next_s.irq = next_s.flags[0] & next_s.en[0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.port <= `CCU_PORT_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign first_timer_reset = s.t1rst;
  assign third_timer_reset = s.t3rst;
  assign unit_output_pin = s.pout;
  assign unit_output_pin_oe = s.poe;
  assign special_event = s.spev;
  assign irq = s.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence hit0_s;
    ce && hit[0];
  endsequence

  sequence set_mode0_s;
    s.ctrl[0][3:0] == `CCU_MODE_SET && (!wr_en || addr != `CCU_CTRL);
  endsequence

  match_sets_flag_a: assert property ( // R4
    hit0_s |=> s.flags[0]
  ) else $error("match did not set the unit flag");

  flag_sticky_a: assert property ( // R16
    ce && s.flags[0] && !(wr_en && addr == `CCU_FLAGS && wdata[0])
    |=> s.flags[0]
  ) else $error("unit flag dropped without a clear");

  drive_high_a: assert property ( // R2
    hit0_s and set_mode0_s |=> unit_output_pin[0]
  ) else $error("set action did not drive the pin high");

  drive_low_a: assert property ( // R18
    hit0_s and (s.ctrl[0][3:0] == `CCU_MODE_CLR
      && !(wr_en && addr == `CCU_CTRL))
    |=> !unit_output_pin[0]
  ) else $error("clear action did not drive the pin low");

  toggle_pin_a: assert property ( // R2
    hit0_s and (s.ctrl[0][3:0] == `CCU_MODE_TOGGLE
      && !(wr_en && addr == `CCU_CTRL))
    |=> unit_output_pin[0] != $past(s.clat[0])
  ) else $error("toggle action did not invert the pin");

  swi_pin_a: assert property ( // R5
    ce && s.ctrl[0][3:0] == `CCU_MODE_SWI && !wr_en
    |=> unit_output_pin[0] == $past(s.port[`CCU_PORT_LATCH])
  ) else $error("software interrupt mode touched the pin");

  trig_reset_a: assert property ( // R7
    hit0_s and (s.ctrl[0][3:0] == `CCU_MODE_TRIG)
    |=> special_event[0] && (third_timer_reset == $past(use_t3[0]))
      && (first_timer_reset == !$past(use_t3[0]))
  ) else $error("trigger did not reset the selected timer");

  off_latch_a: assert property ( // R8
    ce && wr_en && addr == `CCU_CTRL && wdata == 8'h00
    |=> !s.clat[0] ##1 (!ce || s.ctrl[0] != 6'h00 || !s.clat[0])
  ) else $error("unit off did not hold the latch low");

  ctrl_top_zero_a: assert property ( // R13
    ce && rd_en && addr == `CCU_CTRL |=> rdata[7:6] == 2'b00
  ) else $error("control bits 7:6 read nonzero");

  presc_clear_a: assert property ( // R15
    ce && s.ctrl[0][3:2] != `CCU_MODE_CAP
    && !(wr_en && addr == `CCU_CTRL) |=> s.presc[0] == 4'h0
  ) else $error("prescaler not cleared outside capture");

  irq_level_a: assert property ( // R5
    ##1 irq == |(s.flags & s.en)
  ) else $error("interrupt output disagrees with flags");

  sequence pwm_run0_s;
    ce && s.ctrl[0][3:2] == `CCU_MODE_PWM && !wr_en;
  endsequence

  enh_flag_set_a: assert property ( // R4
    ce && hit[1] |=> s.flags[1]
  ) else $error("match did not set the enhanced flag");

  flag_only_hit_a: assert property ( // R4
    ce && !s.flags[0] && !hit[0] |=> !s.flags[0]
  ) else $error("unit flag set without a match");

  flag_w1c_a: assert property ( // R16
    ce && wr_en && addr == `CCU_FLAGS && wdata[0] && !hit[0] |=> !s.flags[0]
  ) else $error("unit flag not cleared by a one");

  trig_only_a: assert property ( // R6
    ce && !(hit[0] && s.ctrl[0][3:0] == `CCU_MODE_TRIG) |=> !special_event[0]
  ) else $error("trigger pulse without a trigger match");

  off_pin_port_a: assert property ( // R3
    ce && !wr_en && s.ctrl[0][3:0] == `CCU_MODE_OFF
    |=> unit_output_pin[0] == $past(s.port[`CCU_PORT_LATCH])
  ) else $error("idle unit pin does not follow the port latch");

  oe_from_dir_a: assert property ( // R9
    ce |=> unit_output_pin_oe[0] == !s.port[`CCU_PORT_DIR]
  ) else $error("pin enable disagrees with the direction bit");

  pwm_period_set_a: assert property ( // R11
    pwm_run0_s and second_timer_wrap
    |=> unit_output_pin[0]
      == ($past(s.cmp_lo[0]) != 8'h00 || $past(s.ctrl[0][5:4]) != 2'b00)
  ) else $error("period start did not set the pin per the duty");

  pwm_duty_end_a: assert property ( // R11
    pwm_run0_s and (!second_timer_wrap
      && {s.cmp_hi[0], s.dlat2[0]} == {second_timer_count, second_timer_fine})
    |=> !unit_output_pin[0]
  ) else $error("duty match did not clear the pin");

  pwm_hi_locked_a: assert property ( // R11
    pwm_run0_s and !second_timer_wrap |=> $stable(s.cmp_hi[0])
  ) else $error("duty buffer moved outside a period start");

  presc_count_a: assert property ( // R15
    ce && !wr_en && s.ctrl[0][3:2] == `CCU_MODE_CAP && cap_event[0]
    |=> s.presc[0] == $past(s.presc[0]) + 4'h1
  ) else $error("prescaler missed a capture event");

  ctrl_write_a: assert property ( // R13
    ce && wr_en && addr == `CCU_CTRL |=> s.ctrl[0] == $past(wdata[5:0])
  ) else $error("control write not taken");

  tsel_read_a: assert property ( // R17
    ce && rd_en && addr == `CCU_TSEL
    |=> rdata == {1'b0, $past(s.tsel[1]), 2'b00, $past(s.tsel[0]), 3'b000}
  ) else $error("timer select read back wrong");

  unmapped_read_a: assert property ( // R13
    ce && rd_en && addr > `CCU_PRESC |=> rdata == 8'h00
  ) else $error("unmapped address read nonzero");

endmodule // ccu_compare_unit

// ===== design/ccu_params.svh
// Contract
// R1: Compare the 16-bit compare value with the selected timer every cycle.
// R2: On match, drive the pin high, low, toggle it, or leave it.
// R3: In no-change action the pin follows the port output latch.
// R4: Every compare match sets the unit interrupt flag in that cycle; the code registers the flag, so it shows one cycle after the match.
// R5: Mode 1010 leaves the pin alone; flag only, interrupt only if enabled.
// R6: Mode 1011 emits a special event trigger pulse on match.
// R7: The special event trigger resets the currently selected timer.
// R8: Writing zero to the control register forces the compare latch low.
// R9: Software clears the pin direction bit before using output modes.
// R10: The time base timer runs in timer or synchronized counter mode.
// R11: PWM mode drives a waveform with up to ten bits of duty.
// R12: Software switches the unit off before loading a new prescaler mode.
// R13: Unimplemented register bits, including control bits 7:6, read as zero; without the enhanced unit, port bit 3 reads as one.
// R14: The enhanced second unit exists only on larger variants.
// R15: The capture prescaler is cleared when off or not capturing.
// R16: The interrupt flag stays set until software clears it.
// R17: Timer select bits in the third timer control pick each time base.
// R18: Pin actions: 1000 drive high, 1001 drive low, 0010 toggle.
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// Register offsets
`define CCU_CMP_LO 4'h0
`define CCU_CMP_HI 4'h1
`define CCU_CTRL 4'h2
`define CCU_UNIT_STRIDE 4'h3
`define CCU_TSEL 4'h6
`define CCU_FLAGS 4'h7
`define CCU_ENABLES 4'h8
`define CCU_PORT 4'h9
`define CCU_PRESC 4'hA

// Field positions
`define CCU_TSEL_HIGH 6
`define CCU_TSEL_LOW 3
`define CCU_PORT_LATCH 0
`define CCU_PORT_DIR 1

// Reset values
`define CCU_PORT_RST 4'hA

// Mode encodings
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_TOGGLE 4'h2
`define CCU_MODE_SET 4'h8
`define CCU_MODE_CLR 4'h9
`define CCU_MODE_SWI 4'hA
`define CCU_MODE_TRIG 4'hB
`define CCU_MODE_CAP 2'b01
`define CCU_MODE_PWM 2'b11

`endif

// ===== design/ccu_pkg.sv
package ccu_pkg;

  typedef enum logic [1:0] {
    CCU_ACT_NONE,
    CCU_ACT_HIGH,
    CCU_ACT_LOW,
    CCU_ACT_TOGGLE
  } ccu_act_t;

  typedef struct packed {
    logic [1:0][7:0] cmp_lo;
    logic [1:0][7:0] cmp_hi;
    logic [1:0][5:0] ctrl;
    logic [1:0][1:0] dlat2;
    logic [1:0][3:0] presc;
    logic [1:0] tsel;
    logic [1:0] flags;
    logic [1:0] en;
    logic [3:0] port;
    logic [1:0] eq;
    logic [1:0] clat;
    logic [1:0] pout;
    logic [1:0] poe;
    logic [1:0] spev;
    logic t1rst;
    logic t3rst;
    logic irq;
    logic [7:0] rdata;
  } ccu_state_t;

endpackage : ccu_pkg
